//--- hw/csm_arb.sv
// fixed-priority request multiplexer for the break channels
`timescale 1ns/1ns
module csm_arb (
  input wire logic [csm_pkg::NDEV-1:0] req,
  output logic any,
  output logic [csm_pkg::SEL_W-1:0] idx
);
  // lowest channel wins; a busy low channel can starve higher ones
  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = csm_pkg::NDEV - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = csm_pkg::SEL_W'(i);
      end
    end
  end
endmodule // csm_arb

//--- hw/csm_fifo.sv
// write buffer between the break port and the core memory write port
`timescale 1ns/1ns
module csm_fifo #(
  parameter int WIDTH = csm_pkg::FIFO_WIDTH,
  parameter int DEPTH = csm_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  // pointers wrap by overflow, so depth must be a power of two
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } csm_fifo_st_t;

  csm_fifo_st_t st_r;
  csm_fifo_st_t st_nxt;
  logic push;
  logic pop;

  assign in_ready = (st_r.cnt != FULL);
  assign out_valid = (st_r.cnt != '0);
  assign out_data = st_r.mem[st_r.rp];

  always_comb begin
    st_nxt = st_r;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    if (push) begin
      st_nxt.mem[st_r.wp] = in_data;
      st_nxt.wp = st_r.wp + AW'(1);
    end
    if (pop) begin
      st_nxt.rp = st_r.rp + AW'(1);
    end
    if (push && !pop) begin
      st_nxt.cnt = st_r.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      st_nxt.cnt = st_r.cnt - (AW+1)'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule // csm_fifo

//--- hw/csm_port.sv
// computer side of the cycle-steal memory port
//
// Summary of operation
// - one device steals memory cycles for transfers
// - up to four devices through request multiplexer
// - words move between buffer register and device, both ways
// - sustain up to 571,000 words each second
// - 15-bit address, 18-bit data, one asserted
// - 70 ns strobe when address is loaded; here one 100 ns clock
// - 70 ns strobe when word is loaded; here one 100 ns clock
// - 400 ns strobe when buffer word ready
// - request sampled at delayed phase five
// - address strobe at phase one each break
// - word strobe at phase three, inbound only
// - ready strobe at phase three, every break
`timescale 1ns/1ns
module csm_port (
  input wire logic clk,
  input wire logic reset,
  input wire csm_pkg::csm_dev_t [csm_pkg::NDEV-1:0] dev_i,
  input wire logic instr_done,
  output logic break_state,
  output logic [csm_pkg::NDEV-1:0] address_accepted_strobe,
  output logic [csm_pkg::NDEV-1:0] word_accepted_strobe,
  output logic [csm_pkg::NDEV-1:0] data_ready_strobe,
  output logic [csm_pkg::DATA_W-1:0] data_out,
  output logic mem_rd_en,
  output logic [csm_pkg::ADDR_W-1:0] mem_rd_addr,
  input wire logic [csm_pkg::DATA_W-1:0] mem_rd_data,
  output logic mem_wr_valid,
  input wire logic mem_wr_ready,
  output logic [csm_pkg::ADDR_W-1:0] mem_wr_addr,
  output logic [csm_pkg::DATA_W-1:0] mem_wr_data
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  csm_pkg::csm_st_t st_r;
  csm_pkg::csm_st_t st_nxt;

  logic [csm_pkg::NDEV-1:0] req_sync;
  logic req_any;
  logic [csm_pkg::SEL_W-1:0] req_idx;
  logic fifo_in_ready;
  csm_pkg::csm_wr_t fifo_in;
  csm_pkg::csm_wr_t fifo_out;
  csm_pkg::csm_dev_t cur;
  logic fifo_out_valid;
  logic fifo_out_ready;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [csm_pkg::NDEV-1:0] onehot(
    input logic [csm_pkg::SEL_W-1:0] s
  );
    logic [csm_pkg::NDEV-1:0] v;
    v = '0;
    v[s] = 1'b1;
    return v;
  endfunction

  // strobe length counter: load on trigger, count down to zero
  function automatic logic [2:0] stb_step(
    input logic [2:0] cnt,
    input logic load,
    input logic [2:0] len
  );
    logic [2:0] v;
    v = cnt;
    if (load) begin
      v = len;
    end else if (cnt != 3'h0) begin
      v = cnt - 3'h1;
    end
    return v;
  endfunction

  // ---------------------------------------------------------------
  // request multiplexer
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < csm_pkg::NDEV; g++) begin : g_req
      assign req_sync[g] = st_r.s2[g].req;
    end
  endgenerate

  csm_arb u_arb (
    .req(req_sync),
    .any(req_any),
    .idx(req_idx)
  );

  // ---------------------------------------------------------------
  // write buffer toward core memory
  // ---------------------------------------------------------------
  assign fifo_in.addr = {st_r.extended_address_bits, st_r.memory_address_register};
  assign fifo_in.data = st_r.memory_buffer_register;

  csm_fifo #(
    .WIDTH(csm_pkg::FIFO_WIDTH),
    .DEPTH(csm_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset(reset),
    .in_valid(st_r.push),
    .in_data(fifo_in),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out),
    .out_ready(fifo_out_ready)
  );

  // a one-word stage keeps the write port straight off flops; it adds
  // one word of room, so a stalled port holds one word beyond the buffer
  assign fifo_out_ready = !st_r.wr_valid || mem_wr_ready;

  // ---------------------------------------------------------------
  // next-state logic
  // ---------------------------------------------------------------
  assign cur = st_r.s2[st_r.gsel];

  always_comb begin
    logic at_t1;
    logic at_t3;
    logic word_in;
    at_t1 = 1'b0;
    at_t3 = 1'b0;
    word_in = 1'b0;
    st_nxt = st_r;

    // pins come from the device's own timing, so two stages first
    st_nxt.s1 = dev_i;
    st_nxt.s2 = st_r.s1;

    // memory cycle phase counter
    if (st_r.phase == csm_pkg::PH_LAST) begin
      st_nxt.phase = 5'h00;
    end else begin
      st_nxt.phase = st_r.phase + 5'h01;
    end

    // break request sampled once per cycle at the delayed phase five;
    // a full write buffer holds the request off rather than drop a word
    if (st_r.phase == csm_pkg::PH_T5D) begin
      st_nxt.data_sync = req_any && fifo_in_ready;
      st_nxt.sel = req_idx;
    end

    // break state starts with the next cycle after an instruction
    // completes, or straight after a break when still requested
    if (st_r.phase == csm_pkg::PH_LAST) begin
      st_nxt.brk = st_r.data_sync && (st_r.brk || instr_done);
      st_nxt.gsel = st_r.sel;
    end

    at_t1 = st_r.brk && (st_r.phase == csm_pkg::PH_T1);
    at_t3 = st_r.brk && (st_r.phase == csm_pkg::PH_T3);
    word_in = at_t3 && (cur.dir == csm_pkg::CSM_DIR_IN);

    // phase one: device address into the address registers
    st_nxt.rd_en = at_t1;
    if (at_t1) begin
      st_nxt.extended_address_bits = cur.addr[csm_pkg::ADDR_W-1 -: csm_pkg::EXT_W];
      st_nxt.memory_address_register = cur.addr[csm_pkg::MA_W-1:0];
      st_nxt.rd_addr = cur.addr;
    end

    // phase three: buffer register takes the device word or the
    // memory word; nothing else in the processor is touched
    st_nxt.push = word_in;
    if (word_in) begin
      st_nxt.memory_buffer_register = cur.data;
    end else if (at_t3) begin
      st_nxt.memory_buffer_register = mem_rd_data;
    end

    // strobes, routed to the granted channel only
    st_nxt.aa_cnt = stb_step(st_r.aa_cnt, at_t1, csm_pkg::ADDR_STB_LEN);
    st_nxt.wa_cnt = stb_step(st_r.wa_cnt, word_in, csm_pkg::WORD_STB_LEN);
    st_nxt.dr_cnt = stb_step(st_r.dr_cnt, at_t3, csm_pkg::READY_STB_LEN);

    st_nxt.aa = (st_nxt.aa_cnt != 3'h0) ? onehot(st_r.gsel) : '0;
    st_nxt.wa = (st_nxt.wa_cnt != 3'h0) ? onehot(st_r.gsel) : '0;
    st_nxt.dr = (st_nxt.dr_cnt != 3'h0) ? onehot(st_r.gsel) : '0;

    // write port stage: refill whenever empty or being taken
    if (fifo_out_ready) begin
      st_nxt.wr_valid = fifo_out_valid;
      st_nxt.wr = fifo_out;
    end
  end

  // ---------------------------------------------------------------
  // state register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= csm_pkg::CSM_ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign break_state = st_r.brk;
  assign address_accepted_strobe = st_r.aa;
  assign word_accepted_strobe = st_r.wa;
  assign data_ready_strobe = st_r.dr;
  // buffer word stays put until the next break, so a delayed capture
  // by the device still sees it
  assign data_out = st_r.memory_buffer_register;
  assign mem_rd_en = st_r.rd_en;
  assign mem_rd_addr = st_r.rd_addr;
  assign mem_wr_valid = st_r.wr_valid;
  assign mem_wr_addr = st_r.wr.addr;
  assign mem_wr_data = st_r.wr.data;

  // a read break does not look into words still queued for writing;
  // software must not read back a location it has just had written
endmodule // csm_port

//--- include/csm_pkg.sv
// constants, carriers and state layout of the cycle-steal memory port
package csm_pkg;

  // ---------------------------------------------------------------
  // bus widths and channel count
  // ---------------------------------------------------------------
  localparam int ADDR_W = 15;
  localparam int DATA_W = 18;
  localparam int EXT_W = 2;
  localparam int MA_W = ADDR_W - EXT_W;
  localparam int NDEV = 4;
  localparam int SEL_W = 2;

  // ---------------------------------------------------------------
  // clock and memory cycle timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 10000000;
  localparam int CLK_NS = 100;
  localparam int WORD_RATE = 571000;
  // floor keeps the cycle short enough for the full word rate
  localparam int CYCLE_CLKS = CLK_HZ / WORD_RATE;
  localparam int T1_NS = 0;
  localparam int T3_NS = 800;
  localparam int T5_NS = 1400;
  localparam int DELAYED_PHASE_FIVE_PULSE_NS = 50;
  localparam int ADDR_STB_NS = 70;
  localparam int WORD_STB_NS = 70;
  localparam int READY_STB_NS = 400;
  localparam int T1_CLKS = T1_NS / CLK_NS;
  localparam int T3_CLKS = (T3_NS + CLK_NS - 1) / CLK_NS;
  localparam int T5D_CLKS = (T5_NS + DELAYED_PHASE_FIVE_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int ADDR_STB_CLKS = (ADDR_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int WORD_STB_CLKS = (WORD_STB_NS + CLK_NS - 1) / CLK_NS;
  localparam int READY_STB_CLKS = (READY_STB_NS + CLK_NS - 1) / CLK_NS;

  localparam logic [4:0] PH_T1 = 5'(T1_CLKS);
  localparam logic [4:0] PH_T3 = 5'(T3_CLKS);
  localparam logic [4:0] PH_T5D = 5'(T5D_CLKS);
  localparam logic [4:0] PH_LAST = 5'(CYCLE_CLKS - 1);
  localparam logic [2:0] ADDR_STB_LEN = 3'(ADDR_STB_CLKS);
  localparam logic [2:0] WORD_STB_LEN = 3'(WORD_STB_CLKS);
  localparam logic [2:0] READY_STB_LEN = 3'(READY_STB_CLKS);

  // ---------------------------------------------------------------
  // write buffer
  // ---------------------------------------------------------------
  localparam int FIFO_WIDTH = ADDR_W + DATA_W;
  localparam int FIFO_DEPTH = 32;
  // words held before grants stop: the buffer plus the write port stage
  localparam int WR_ROOM = FIFO_DEPTH + 1;

  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef enum logic {
    CSM_DIR_OUT = 1'b0,
    CSM_DIR_IN = 1'b1
  } csm_dir_t;

  typedef struct packed {
    logic req;
    csm_dir_t dir;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } csm_dev_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } csm_wr_t;

  typedef struct packed {
    logic [4:0] phase;
    csm_dev_t [NDEV-1:0] s1;
    csm_dev_t [NDEV-1:0] s2;
    logic data_sync;
    logic [SEL_W-1:0] sel;
    logic brk;
    logic [SEL_W-1:0] gsel;
    logic [EXT_W-1:0] extended_address_bits;
    logic [MA_W-1:0] memory_address_register;
    logic [DATA_W-1:0] memory_buffer_register;
    logic [2:0] aa_cnt;
    logic [2:0] wa_cnt;
    logic [2:0] dr_cnt;
    logic [NDEV-1:0] aa;
    logic [NDEV-1:0] wa;
    logic [NDEV-1:0] dr;
    logic rd_en;
    logic [ADDR_W-1:0] rd_addr;
    logic push;
    logic wr_valid;
    csm_wr_t wr;
  } csm_st_t;

  localparam csm_st_t CSM_ST_RESET = '0;

endpackage

//--- testbench/csm_dev_model.sv
// behavioural model of one device controller on a break channel
`timescale 1ns/1ns
module csm_dev_model (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire csm_pkg::csm_dir_t dir,
  input wire logic [csm_pkg::ADDR_W-1:0] addr,
  input wire logic [csm_pkg::DATA_W-1:0] data,
  input wire logic aa,
  input wire logic wa,
  input wire logic dr,
  input wire logic [csm_pkg::DATA_W-1:0] data_out,
  output csm_pkg::csm_dev_t dev,
  output logic busy,
  output logic [csm_pkg::DATA_W-1:0] got
);
  logic dr_q;
  // lines no longer needed are inverted, so a late sample shows up
  always @(posedge clk) begin
    dr_q <= dr;
    if (reset) begin
      dev <= '0;
      busy <= 1'b0;
      got <= '0;
    end else if (start) begin
      dev <= '{1'b1, dir, addr, data};
      busy <= 1'b1;
    end else begin
      if (aa) begin
        dev.req <= 1'b0;
        dev.addr <= ~dev.addr;
      end
      if (wa) begin
        dev.data <= ~dev.data;
      end
      if (dr && !dr_q) begin
        got <= data_out;
        dev.dir <= csm_pkg::csm_dir_t'(~dev.dir);
        busy <= 1'b0;
      end
    end
  end
endmodule // csm_dev_model

//--- testbench/csm_port_checker.sv
// port assertions for the cycle-steal memory port
`timescale 1ns/1ns
module csm_port_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic break_state,
  input wire logic [csm_pkg::NDEV-1:0] address_accepted_strobe,
  input wire logic [csm_pkg::NDEV-1:0] word_accepted_strobe,
  input wire logic [csm_pkg::NDEV-1:0] data_ready_strobe,
  input wire logic [csm_pkg::DATA_W-1:0] data_out,
  input wire logic mem_rd_en,
  input wire logic mem_wr_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // ---------------------------------------------------------------
  // strobe sequences
  // ---------------------------------------------------------------
  sequence s_start;
    $rose(break_state);
  endsequence
  sequence s_addr;
    (|address_accepted_strobe) && mem_rd_en ##1 !(|address_accepted_strobe);
  endsequence
  sequence s_ready;
    (|data_ready_strobe)[*4] ##1 !(|data_ready_strobe);
  endsequence
  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  AST_ADDR_T1: assert property (s_start |=> s_addr)
    else $error("address strobe missing at phase one");
  AST_READY_T3: assert property ($rose(|address_accepted_strobe) |-> ##8 s_ready)
    else $error("ready strobe wrong place or length");
  AST_WORD: assert property ((|word_accepted_strobe) |->
    word_accepted_strobe == data_ready_strobe && $rose(|data_ready_strobe)
    ##1 !(|word_accepted_strobe))
    else $error("word strobe wrong");
  AST_QUIET: assert property (!break_state |-> !(|address_accepted_strobe) &&
    !(|word_accepted_strobe) && !(|data_ready_strobe))
    else $error("strobe outside break");
  AST_BRK_LEN: assert property (s_start |->
    break_state[*8] ##1 break_state[*8] ##1 break_state)
    else $error("break cycle too short");
  AST_SAME_CH: assert property ($rose(|data_ready_strobe) |->
    $onehot(data_ready_strobe) && data_ready_strobe == $past(address_accepted_strobe, 8))
    else $error("strobes on different channels");
  AST_DATA_HOLD: assert property ($changed(data_out) |-> $rose(|data_ready_strobe))
    else $error("data out changed outside phase nine");
  AST_RD: assert property (mem_rd_en |-> |address_accepted_strobe)
    else $error("memory read outside address strobe");
  // the write port stage puts one edge between the push and the port
  AST_PUSH: assert property ((|word_accepted_strobe) |-> ##2 mem_wr_valid)
    else $error("inbound word not queued");
endmodule // csm_port_checker

bind csm_port csm_port_checker CHK (.clk(clk), .reset(reset), .break_state(break_state),
  .address_accepted_strobe(address_accepted_strobe), .word_accepted_strobe(word_accepted_strobe),
  .data_ready_strobe(data_ready_strobe), .data_out(data_out), .mem_rd_en(mem_rd_en),
  .mem_wr_valid(mem_wr_valid));

//--- testbench/testbench.sv
// self-checking bench for the cycle-steal memory port
`timescale 1ns/1ns
module testbench;
  localparam int N = csm_pkg::NDEV;
  logic clk, reset, instr_done, mem_wr_ready, brk, mem_rd_en, mem_wr_valid;
  logic [N-1:0] start, busy, aa, wa, dr, last_aa;
  csm_pkg::csm_dir_t dir;
  logic [csm_pkg::ADDR_W-1:0] addr, mem_rd_addr, mem_wr_addr;
  logic [csm_pkg::DATA_W-1:0] data, data_out, mem_rd_data, mem_wr_data;
  logic [N-1:0][csm_pkg::DATA_W-1:0] got;
  csm_pkg::csm_dev_t [N-1:0] dev;
  csm_pkg::csm_wr_t exp_q [$];
  int fail_count = 0;
  int num_checks = 0;
  int wa_n = 0;

  function automatic logic [17:0] pat(input logic [14:0] a);
    return {3'h5, a} ^ 18'h0a5a5;
  endfunction
  assign mem_rd_data = pat(mem_rd_addr);

  csm_port DUT (.clk(clk), .reset(reset), .dev_i(dev), .instr_done(instr_done),
    .break_state(brk), .address_accepted_strobe(aa), .word_accepted_strobe(wa),
    .data_ready_strobe(dr), .data_out(data_out), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_valid(mem_wr_valid),
    .mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data));
  for (genvar i = 0; i < N; i++) begin : g_dev
    csm_dev_model M (.clk(clk), .reset(reset), .start(start[i]), .dir(dir), .addr(addr),
      .data(data), .aa(aa[i]), .wa(wa[i]), .dr(dr[i]), .data_out(data_out), .dev(dev[i]),
      .busy(busy[i]), .got(got[i]));
  end

  // ---------------------------------------------------------------
  // shared tasks and monitors
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic req(input int ch, input csm_pkg::csm_dir_t d, input logic [14:0] a,
                     input logic [17:0] v);
    @(posedge clk) #10;
    dir = d;
    addr = a;
    data = v;
    start[ch] = 1'b1;
    if (d == csm_pkg::CSM_DIR_IN) exp_q.push_back({a, v});
    @(posedge clk) #10;
    start[ch] = 1'b0;
  endtask
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy !== '0 && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(busy, 4'h0);
  endtask
  always @(posedge clk) begin
    if (|aa) last_aa <= aa;
    if (|wa) wa_n++;
    if (mem_wr_valid && mem_wr_ready) chk({mem_wr_addr, mem_wr_data}, exp_q.pop_front());
  end

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_in;
    int w;
    w = wa_n;
    req(0, csm_pkg::CSM_DIR_IN, 15'h7fff, 18'h3ffff);
    wait_idle(100);
    chk(got[0], 18'h3ffff);
    chk(last_aa, 4'h1);
    chk(wa_n - w, 32'h1);
  endtask
  task automatic t_out;
    int w;
    w = wa_n;
    req(3, csm_pkg::CSM_DIR_OUT, 15'h4001, 18'h00000);
    wait_idle(100);
    chk(got[3], pat(15'h4001));
    chk(last_aa, 4'h8);
    chk(wa_n - w, 32'h0);
  endtask
  task automatic t_prio;
    int n;
    @(posedge clk) #10;
    dir = csm_pkg::CSM_DIR_OUT;
    addr = 15'h0123;
    start = 4'h6;
    @(posedge clk) #10;
    start = 4'h0;
    n = 0;
    while (busy[1] !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chk(busy[2], 1'b1);
    wait_idle(100);
    chk(last_aa, 4'h4);
  endtask
  task automatic t_hold;
    // let the running break end first, or a request raised now rides on
    // it into a back-to-back break whatever the instruction timing says
    repeat (20) @(posedge clk);
    #10 instr_done = 1'b0;
    req(1, csm_pkg::CSM_DIR_OUT, 15'h0000, 18'h00000);
    repeat (60) @(posedge clk);
    chk(brk, 1'b0);
    chk(busy[1], 1'b1);
    #10 instr_done = 1'b1;
    wait_idle(100);
    chk(got[1], pat(15'h0000));
  endtask
  task automatic t_full;
    #10 mem_wr_ready = 1'b0;
    // one request more than the buffer and the write port stage can hold
    for (int i = 0; i <= csm_pkg::WR_ROOM; i++) begin
      req(0, csm_pkg::CSM_DIR_IN, 15'(i), 18'(i * 3 + 1));
      if (i < csm_pkg::WR_ROOM) wait_idle(100);
    end
    repeat (100) @(posedge clk);
    chk(busy[0], 1'b1);
    #10 mem_wr_ready = 1'b1;
    wait_idle(200);
    repeat (60) @(posedge clk);
    chk(exp_q.size(), 32'h0);
  endtask

  // ---------------------------------------------------------------
  // clock, reset, sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    reset = 1'b1;
    instr_done = 1'b1;
    mem_wr_ready = 1'b1;
    start = '0;
    dir = csm_pkg::CSM_DIR_OUT;
    addr = '0;
    data = '0;
    repeat (8) @(posedge clk);
    #10 reset = 1'b0;
    t_in;
    t_out;
    t_prio;
    t_hold;
    t_full;
    close_out;
  end
  // whole run is about 1000 cycles; allow some twenty times that
  initial begin
    #2000000;
    fail_count++;
    close_out;
  end
endmodule // testbench
